// >>> design/ucd_pkg.sv
package ucd_pkg;

    // Register map (word offsets as byte addresses)
    localparam logic [3:0] CMD_OFFSET    = 4'h0;
    localparam logic [3:0] STATE_OFFSET  = 4'h4;
    localparam logic [3:0] MODE_OFFSET   = 4'h8;
    localparam int         ADDR_W        = 4;

    // Command field positions
    localparam int GEN_HI = 6;
    localparam int GEN_LO = 4;
    localparam int TXC_HI = 3;
    localparam int TXC_LO = 2;
    localparam int RXC_HI = 1;
    localparam int RXC_LO = 0;

    // Mode register bit positions
    localparam int MODE_PM_HI   = 1;
    localparam int MODE_PM_LO   = 0;
    localparam int MODE_LOOP    = 2;

    // Status register bit positions
    localparam int ST_TX_EN   = 0;
    localparam int ST_RX_EN   = 1;
    localparam int ST_BREAK   = 2;
    localparam int ST_TX_PEND = 3;

    localparam logic [1:0] PM_MULTIDROP = 2'h3;
    localparam logic [2:0] MODE_RESET   = 3'h0;

    // Timing
    localparam int CLK_HZ       = 20000000;
    localparam int BAUD_DEFAULT = 115200;

    typedef enum logic [2:0] {
        GEN_NONE, GEN_MODE_PTR, GEN_RX_RESET, GEN_TX_RESET,
        GEN_ERR_RESET, GEN_DB_RESET, GEN_BRK_START, GEN_BRK_STOP
    } ucd_gen_t;

    typedef enum logic [1:0] {
        SUB_NONE, SUB_ENABLE, SUB_DISABLE, SUB_RSVD
    } ucd_sub_t;

    // One-shot strobes towards the surrounding channel logic
    typedef struct packed {
        logic mode_ptr_reset;
        logic rx_fifo_reinit;
        logic rx_status_clear;
        logic tx_status_clear;
        logic tx_status_set;
        logic err_status_clear;
        logic delta_break_clear;
        logic rx_hunt_start;
    } ucd_strobe_t;

    // Live transmitter state: synced shifting flag plus the decoder's own bit-clock tick
    typedef struct packed {
        logic shifting;
        logic bit_tick;
    } ucd_tx_state_t;

endpackage

// >>> design/ucd_break_ctl.sv
`timescale 1ns/100ps
module ucd_break_ctl
    import ucd_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          start_req,
    input  wire logic          stop_req,
    input  wire logic          tx_abort,
    input  wire ucd_tx_state_t tx_state,
    output logic               break_active,
    output logic               break_pending
);
    typedef enum logic [1:0] {BK_IDLE, BK_WAIT, BK_ON, BK_END} ucd_bk_t;

    ucd_bk_t st_reg;
    ucd_bk_t st_next;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            BK_IDLE: begin
                if (start_req)
                    st_next = BK_WAIT;
            end
            // Idle line: wait one bit tick; busy: wait for the character
            BK_WAIT: begin
                if (stop_req || tx_abort)
                    st_next = BK_IDLE;
                else if (!tx_state.shifting && tx_state.bit_tick)
                    st_next = BK_ON;                      // [R08]
            end
            BK_ON: begin
                if (stop_req || tx_abort)
                    st_next = BK_END;
            end
            // Mark is restored on leaving BK_ON; BK_END returns to idle at the next bit tick
            BK_END: begin
                if (tx_state.bit_tick)
                    st_next = BK_IDLE;                    // [R10]
            end
            default: st_next = BK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            st_reg <= BK_IDLE;
        else
            st_reg <= st_next;
    end

    assign break_active  = (st_reg == BK_ON);             // [R08]
    assign break_pending = (st_reg != BK_IDLE);
endmodule

// >>> design/ucd_command_decoder.sv
// Contract
// [R01] Command write decodes general 6-4, transmitter 3-2, receiver 1-0 fields.
// [R02] General 001 resets the mode-register pointer to the first mode register.
// [R03] General 010 disables receiver, clears full/ready, reinitialises FIFO.
// [R04] Software should prefer reset commands over plain disable to reconfigure.
// [R05] General 011 disables transmitter and clears empty/ready status.
// [R06] General 100 clears break, framing, parity and overrun error flags.
// [R07] General 101 clears the delta-break interrupt flag.
// [R08] General 110 drives serial output low after current character.
// [R09] Start-break accepted only with transmitter enabled; clear-to-send ignored.
// [R10] General 111 restores mark within two bit times, then resumes data.
// [R11] Transmitter code 00 keeps transmitter enable unchanged.
// [R12] Transmitter 01 enables and sets empty/ready; no effect if enabled.
// [R13] Transmitter 10 clears empty/ready, stops after current character.
// [R14] Software never writes reserved code 11 to either sub-field.
// [R15] Receiver code 00 keeps receiver enable unchanged.
// [R16] Receiver 01 enables and hunts for start bit unless multidrop.
// [R17] Receiver 10 disables at once, keeps status; no effect if disabled.
// [R18] Loop-back or multidrop keeps receiver running despite disable.
// [R19] Only non-conflicting commands may share one write.
// [R20] Bit 7 ignored; command writes are strobes and read back zero.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module ucd_command_decoder
    import ucd_pkg::*;
#(
    parameter int BAUD_HZ = BAUD_DEFAULT
)
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    output logic      [1:0]          avs_response,
    input  wire logic                tx_shifting,
    input  wire logic                cts_n,
    output ucd_strobe_t              strobe,
    output logic                     tx_enabled,
    output logic                     rx_enabled,
    output logic                     rx_running,
    output logic                     serial_tx_break
);
    import ucd_pkg::*;

    // Bit-time counter derived from the module clock
    localparam int BIT_CYCLES_RAW = CLK_HZ / BAUD_HZ;
    localparam int BIT_CYCLES     = (BIT_CYCLES_RAW < 1) ? 1 : BIT_CYCLES_RAW;
    localparam int BIT_CW         = $clog2(BIT_CYCLES + 1);
    localparam logic [BIT_CW-1:0] BIT_LAST = BIT_CW'(BIT_CYCLES - 1);
    localparam logic [BIT_CW-1:0] BIT_ZERO = '0;

    // Two-flop synchroniser for the pin-driven shifting indication
    logic shift_meta_reg;
    logic shift_sync_reg;
    logic cts_meta_reg;
    logic cts_sync_reg;

    logic              tx_en_reg;
    logic              tx_en_next;
    logic              tx_stop_pend_reg;
    logic              tx_stop_pend_next;
    logic              rx_en_reg;
    logic              rx_en_next;
    logic [2:0]        mode_reg;
    logic [BIT_CW-1:0] bit_cnt_reg;
    ucd_strobe_t       strobe_reg;
    ucd_strobe_t       strobe_next;
    logic [31:0]       rdata_reg;
    logic              ack_reg;
    logic [1:0]        resp_reg;

    function automatic ucd_sub_t sub_code(input logic [1:0] f);
        return ucd_sub_t'(f);
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
        return (a == off);
    endfunction

    // Bus decode: one-cycle wait, answer on the second cycle
    wire req        = avs_read | avs_write;
    wire hit_cmd    = addr_hit(avs_address, CMD_OFFSET);
    wire hit_state  = addr_hit(avs_address, STATE_OFFSET);
    wire hit_mode   = addr_hit(avs_address, MODE_OFFSET);
    // Lane 0 holds every command and mode bit; other lanes are ignored
    wire mapped     = hit_cmd | hit_state | hit_mode;
    wire accept     = req & !ack_reg;
    wire cmd_wr     = accept & avs_write & hit_cmd & avs_byteenable[0];
    wire mode_wr    = accept & avs_write & hit_mode & avs_byteenable[0];

    // Bit 7 never reaches the decode                                 [R20]
    wire [2:0] gen_f = avs_writedata[GEN_HI:GEN_LO];                // [R01]
    wire [1:0] txc_f = avs_writedata[TXC_HI:TXC_LO];                // [R01]
    wire [1:0] rxc_f = avs_writedata[RXC_HI:RXC_LO];                // [R01]

    wire ucd_gen_t gen_cmd = cmd_wr ? ucd_gen_t'(gen_f) : GEN_NONE;
    wire ucd_sub_t tx_cmd  = cmd_wr ? sub_code(txc_f) : SUB_NONE;
    wire ucd_sub_t rx_cmd  = cmd_wr ? sub_code(rxc_f) : SUB_NONE;

    wire [1:0] pm_f      = mode_reg[MODE_PM_HI:MODE_PM_LO];
    wire multidrop       = (pm_f == PM_MULTIDROP);
    wire loopback        = mode_reg[MODE_LOOP];
    wire bit_tick        = (bit_cnt_reg == BIT_ZERO);

    wire brk_start = (gen_cmd == GEN_BRK_START) & tx_en_reg;        // [R09]
    wire brk_stop  = (gen_cmd == GEN_BRK_STOP);                     // [R10]
    wire tx_reset  = (gen_cmd == GEN_TX_RESET);
    wire rx_reset  = (gen_cmd == GEN_RX_RESET);
    wire mptr_rst  = (gen_cmd == GEN_MODE_PTR);                     // [R02]
    wire err_clr   = (gen_cmd == GEN_ERR_RESET);                    // [R06]
    wire dbrk_clr  = (gen_cmd == GEN_DB_RESET);                     // [R07]

    // Enable and disable act only on a change of state; a reset in
    // the same write wins over an enable                      [R12] [R16]
    wire tx_turn_on  = (tx_cmd == SUB_ENABLE) & !tx_en_reg & !tx_reset;
    wire tx_turn_off = (tx_cmd == SUB_DISABLE) & tx_en_reg;         // [R13]
    wire rx_turn_on  = (rx_cmd == SUB_ENABLE) & !rx_en_reg & !multidrop
                       & !rx_reset;
    wire rx_turn_off = (rx_cmd == SUB_DISABLE) & rx_en_reg;         // [R17]
    wire brk_active;

    ucd_tx_state_t tx_state;
    assign tx_state.shifting = shift_sync_reg;
    assign tx_state.bit_tick = bit_tick;

    // Transmitter enable; disable waits for the character in flight
    always_comb begin
        tx_en_next        = tx_en_reg;
        tx_stop_pend_next = tx_stop_pend_reg;
        if (tx_reset) begin
            tx_en_next        = 1'b0;                               // [R05]
            tx_stop_pend_next = 1'b0;
        end else if (tx_turn_on) begin
            tx_en_next        = 1'b1;                               // [R12]
            tx_stop_pend_next = 1'b0;
        end else if (tx_turn_off) begin
            tx_stop_pend_next = 1'b1;                               // [R13]
        end else if (tx_stop_pend_reg && !shift_sync_reg) begin
            tx_en_next        = 1'b0;                               // [R13]
            tx_stop_pend_next = 1'b0;
        end
        // Code 00 and reserved 11 leave the enable alone          [R11]
    end

    always_comb begin
        rx_en_next = rx_en_reg;
        if (rx_reset)
            rx_en_next = 1'b0;                                      // [R03]
        // Multidrop leaves the enable bit alone; rx_running covers it
        else if (rx_turn_on)
            rx_en_next = 1'b1;                                      // [R16]
        else if (rx_turn_off)
            rx_en_next = 1'b0;                                      // [R17]
        // Code 00 keeps the receiver as it is                     [R15]
    end

    always_comb begin
        strobe_next                   = '0;
        strobe_next.mode_ptr_reset    = mptr_rst;                   // [R02]
        strobe_next.rx_fifo_reinit    = rx_reset;                   // [R03]
        strobe_next.rx_status_clear   = rx_reset;                   // [R03]
        strobe_next.tx_status_clear   = tx_reset | tx_turn_off;     // [R05]
        strobe_next.tx_status_set     = tx_turn_on;                 // [R12]
        strobe_next.err_status_clear  = err_clr;                    // [R06]
        strobe_next.delta_break_clear = dbrk_clr;                   // [R07]
        strobe_next.rx_hunt_start     = rx_turn_on;                 // [R16]
    end

    // Pin levels pass two flops before any logic reads them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_meta_reg <= 1'b0;
            shift_sync_reg <= 1'b0;
        end else begin
            shift_meta_reg <= tx_shifting;
            shift_sync_reg <= shift_meta_reg;
        end
    end

    // Reset to the negated level so release shows no false change
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cts_meta_reg <= 1'b1;
            cts_sync_reg <= 1'b1;
        end else begin
            cts_meta_reg <= cts_n;
            cts_sync_reg <= cts_meta_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tx_en_reg <= 1'b0;
        else
            tx_en_reg <= tx_en_next;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tx_stop_pend_reg <= 1'b0;
        else
            tx_stop_pend_reg <= tx_stop_pend_next;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rx_en_reg <= 1'b0;
        else
            rx_en_reg <= rx_en_next;
    end

    // Strobes last one cycle; next is zero unless a command lands [R20]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            strobe_reg <= '0;
        else
            strobe_reg <= strobe_next;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mode_reg <= MODE_RESET;
        else if (mode_wr)
            mode_reg <= avs_writedata[MODE_LOOP:MODE_PM_LO];
    end

    // Free-running bit clock: an idle-line break starts within one bit
    wire [BIT_CW-1:0] bit_cnt_dec = bit_cnt_reg - BIT_CW'(1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            bit_cnt_reg <= BIT_ZERO;
        else if (bit_tick)
            bit_cnt_reg <= BIT_LAST;
        else
            bit_cnt_reg <= bit_cnt_dec;
    end

    // Command word is write-only and reads back as zero            [R20]
    localparam int         ST_CTS_LVL  = ST_TX_PEND + 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h2;

    // Synced clear-to-send level is reported only; break ignores it [R09]
    logic [31:0] state_word;
    always_comb begin
        state_word             = '0;
        state_word[ST_TX_EN]   = tx_en_reg;
        state_word[ST_RX_EN]   = rx_en_reg;
        state_word[ST_BREAK]   = brk_active;
        state_word[ST_TX_PEND] = tx_stop_pend_reg;
        state_word[ST_CTS_LVL] = cts_sync_reg;
    end

    wire [31:0] mode_word = {29'h0000000, mode_reg};
    wire [31:0] rd_mux    = hit_state ? state_word :
                            hit_mode  ? mode_word : 32'h0;
    wire [31:0] rd_next   = (accept && avs_read) ? rd_mux : 32'h0;
    wire [1:0]  resp_next = (accept && !mapped) ? RESP_DECERR : RESP_OKAY;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= accept;
    end

    // Read data and response stand for the one answer cycle only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rdata_reg <= 32'h0;
        else
            rdata_reg <= rd_next;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            resp_reg <= RESP_OKAY;
        else
            resp_reg <= resp_next;
    end

    // Break ignores clear-to-send; the synced level is status only [R09]
    ucd_break_ctl u_break (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .start_req     (brk_start),
        .stop_req      (brk_stop),
        .tx_abort      (tx_reset),
        .tx_state      (tx_state),
        .break_active  (brk_active),
        .break_pending ()
    );

    assign avs_waitrequest = req & !ack_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_response    = resp_reg;
    assign strobe          = strobe_reg;
    assign tx_enabled      = tx_en_reg;
    assign rx_enabled      = rx_en_reg;
    assign rx_running      = rx_en_reg | loopback | multidrop;      // [R18]
    assign serial_tx_break = brk_active;
endmodule

// >>> dv/ucd_command_decoder_checker.sv
`timescale 1ns/100ps
module ucd_command_decoder_checker
    import ucd_pkg::*;
#(
    parameter int BAUD_HZ = BAUD_DEFAULT
)
(
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic              avs_waitrequest,
    input wire ucd_strobe_t       strobe,
    input wire logic              tx_enabled,
    input wire logic              rx_enabled,
    input wire logic              serial_tx_break
);
    // Slack on top of two bit times covers the input synchroniser
    localparam int BIT2 = 2 * (CLK_HZ / BAUD_HZ) + 4;
    wire logic take = avs_write && avs_waitrequest && avs_byteenable[0]
                      && avs_address == CMD_OFFSET;
    wire logic [2:0] gen = avs_writedata[GEN_HI:GEN_LO];
    wire logic [1:0] txc = avs_writedata[TXC_HI:TXC_LO];
    wire logic [1:0] rxc = avs_writedata[RXC_HI:RXC_LO];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wait_once_a: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait");
    mode_ptr_a: assert property (take && gen == 3'h1
        |=> strobe.mode_ptr_reset) else $error("mode pointer not reset");
    rx_reset_a: assert property (take && gen == 3'h2
        |=> strobe.rx_fifo_reinit && strobe.rx_status_clear && !rx_enabled)
        else $error("receiver reset wrong");
    tx_reset_a: assert property (take && gen == 3'h3
        |=> strobe.tx_status_clear) else $error("tx status not cleared");
    err_clear_a: assert property (take && gen == 3'h4
        |=> strobe.err_status_clear && !strobe.delta_break_clear)
        else $error("error clear wrong");
    db_clear_a: assert property (take && gen == 3'h5
        |=> strobe.delta_break_clear && !strobe.err_status_clear)
        else $error("delta break clear wrong");
    one_shot_a: assert property (!take |=> strobe == '0)
        else $error("strobe without command");
    tx_enable_a: assert property (take && txc == 2'h1 && !tx_enabled
        && gen != 3'h3 |=> tx_enabled && strobe.tx_status_set)
        else $error("transmitter enable failed");
    rx_disable_a: assert property (take && rxc == 2'h2
        |=> !rx_enabled) else $error("receiver still enabled");
    rx_keep_a: assert property (take && rxc == 2'h0 && gen != 3'h2
        |=> $stable(rx_enabled)) else $error("receiver state changed");
    brk_tx_a: assert property ($rose(serial_tx_break) |-> tx_enabled)
        else $error("break with transmitter off");
    brk_stop_a: assert property (take && gen == 3'h7
        |-> ##[1:BIT2] !serial_tx_break) else $error("break not stopped");
    cover property (take && gen == 3'h6 && tx_enabled);
    cover property ($fell(serial_tx_break));
    cover property (take && rxc == 2'h1 && !rx_enabled);
endmodule
bind ucd_command_decoder ucd_command_decoder_checker #(.BAUD_HZ(BAUD_HZ))
    i_ucd_command_decoder_checker (.clk_sys, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .strobe, .tx_enabled, .rx_enabled, .serial_tx_break);

// >>> dv/ucd_tx_peer.sv
`timescale 1ns/100ps
module ucd_tx_peer #(
    parameter int FRAME = 100
)
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic go,
    output logic      tx_shifting
);
    int cnt;
    // One whole character in the shifter; the break must wait it out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) cnt <= 0;
        else if (go) cnt <= FRAME;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign tx_shifting = (cnt != 0);
endmodule

// >>> dv/test_uart_command_decoder.sv
`timescale 1ns/100ps
module test_uart_command_decoder;
    import ucd_pkg::*;
    logic        clk_sys = 0, rst_n = 0, go = 0, cts_n = 0;
    logic [3:0]  avs_address = 0, avs_byteenable = 4'hF;
    logic        avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [1:0]  avs_response, rsp;
    logic        tx_shifting, tx_enabled, rx_enabled;
    logic        rx_running, serial_tx_break;
    ucd_strobe_t strobe, st;
    int          fail_count = 0, n_checks = 0;
    always #25 clk_sys = ~clk_sys;
    ucd_command_decoder #(.BAUD_HZ(2000000)) i_ucd_command_decoder (
        .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .avs_response, .tx_shifting, .cts_n, .strobe,
        .tx_enabled, .rx_enabled, .rx_running, .serial_tx_break);
    ucd_tx_peer #(.FRAME(100)) i_ucd_tx_peer (.clk_sys, .rst_n, .go,
        .tx_shifting);
    task automatic print_verdict;
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Answer taken at the edge where waitrequest is seen low
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            print_verdict();
        end
        rd = avs_readdata;
        rsp = avs_response;
        st = strobe;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic cmd(logic [7:0] d);
        bus(1, CMD_OFFSET, {24'h0, d});
    endtask
    task automatic wait_lvl(int sel, logic v);
        for (int i = 0; i < 300; i++) begin
            if ((sel == 0 ? tx_enabled : serial_tx_break) === v) return;
            @(negedge clk_sys);
        end
        fail_count++;
        print_verdict();
    endtask
    task automatic send_char;
        go <= 1;
        @(posedge clk_sys);
        go <= 0;
    endtask
    task automatic t_regs;
        bus(0, CMD_OFFSET, 0);
        chk("cmd_read", 0, rd);
        bus(1, 4'hC, 32'h5A);
        chk("unmapped_rsp", 2'h2, rsp);
        bus(0, STATE_OFFSET, 0);
        chk("state_reset", 0, rd[3:0]);
    endtask
    task automatic t_gen;
        logic [7:0] ge [6] = '{8'h00, 8'h80, 8'h60, 8'h10, 8'h04, 8'h02};
        for (int g = 0; g < 6; g++) begin
            cmd(8'h80 | 8'(g << 4));
            chk("gen_strobe", ge[g], st);
        end
    endtask
    task automatic t_tx;
        cmd(8'h04);
        chk("tx_on", 1, tx_enabled);
        chk("tx_set", 8'h08, st);
        cmd(8'h04);
        chk("tx_again", 0, st);
        cmd(8'h80);
        chk("bit7_only", 0, st);
        cmd(8'h00);
        chk("tx_keep", 1, tx_enabled);
        send_char();
        cmd(8'h08);
        chk("tx_dis_strobe", 8'h10, st);
        chk("tx_busy", 1, tx_enabled);
        wait_lvl(0, 0);
        chk("tx_done", 0, tx_shifting);
    endtask
    task automatic t_rx;
        cmd(8'h01);
        chk("rx_on", 1, rx_enabled);
        chk("rx_hunt", 8'h01, st);
        cmd(8'h01);
        chk("rx_again", 0, st);
        cmd(8'h00);
        chk("rx_keep", 1, rx_enabled);
        cmd(8'h02);
        chk("rx_off", 0, rx_enabled);
        chk("rx_off_strobe", 0, st);
        bus(1, MODE_OFFSET, 3);
        cmd(8'h01);
        chk("rx_multidrop", 0, rx_enabled);
        chk("run_multidrop", 1, rx_running);
        bus(1, MODE_OFFSET, 4);
        chk("run_loop", 1, rx_running);
        bus(0, MODE_OFFSET, 0);
        chk("mode_read", 4, rd[2:0]);
        bus(1, MODE_OFFSET, 0);
        chk("run_normal", 0, rx_running);
        cmd(8'h01);
        cmd(8'h20);
        chk("rx_reset", 0, rx_enabled);
    endtask
    task automatic t_brk;
        cmd(8'h60);
        repeat (30) @(negedge clk_sys);
        chk("brk_tx_off", 0, serial_tx_break);
        cmd(8'h04);
        cts_n <= 1;
        send_char();
        cmd(8'h60);
        chk("brk_wait", 0, serial_tx_break);
        wait_lvl(1, 1);
        chk("brk_after_char", 0, tx_shifting);
        bus(0, STATE_OFFSET, 0);
        chk("state_brk", 1, rd[2]);
        chk("cts_level", 1, rd[4]);
        cmd(8'h70);
        wait_lvl(1, 0);
        chk("tx_after_brk", 1, tx_enabled);
        cmd(8'h30);
        wait_lvl(0, 0);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1;
        t_regs();
        t_gen();
        t_tx();
        t_rx();
        t_brk();
        print_verdict();
    end
endmodule
